// file: hw/obc_pkg.sv
package obc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OBC_OFF_OPT0 = 8'h00;
  localparam logic [7:0] OBC_OFF_OPT1 = 8'h04;
  localparam logic [7:0] OBC_OFF_ACTIVE = 8'h08;
  localparam logic [7:0] OBC_OFF_CMD = 8'h0c;
  localparam logic [7:0] OBC_OFF_STATUS = 8'h10;

  // ****************************************
  // Unprogrammed contents
  // ****************************************
  localparam logic [7:0] OBC_OPT0_DEFAULT = 8'hfc;
  localparam logic [7:0] OBC_OPT1_DEFAULT = 8'hef;

  // ****************************************
  // Byte 0 fields
  // ****************************************
  localparam int OBC_B0_RSVD = 7;
  localparam int OBC_B0_RANGE_HI = 6;
  localparam int OBC_B0_RANGE_LO = 4;
  localparam int OBC_B0_SIZE_HI = 3;
  localparam int OBC_B0_SIZE_LO = 2;
  localparam int OBC_B0_RDLOCK = 1;
  localparam int OBC_B0_WRLOCK = 0;

  // ****************************************
  // Byte 1 fields
  // ****************************************
  localparam int OBC_B1_PLLFAC = 7;
  localparam int OBC_B1_PLLBYP = 6;
  localparam int OBC_B1_FTBYP = 5;
  localparam int OBC_B1_RCOFF = 4;
  localparam int OBC_B1_UV_HI = 3;
  localparam int OBC_B1_UV_LO = 2;
  localparam int OBC_B1_WDGSW = 1;
  localparam int OBC_B1_WDGHALT = 0;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [2:0] OBC_RNG_LP = 3'h0;
  localparam logic [2:0] OBC_RNG_MP = 3'h1;
  localparam logic [2:0] OBC_RNG_MS = 3'h2;
  localparam logic [2:0] OBC_RNG_HS = 3'h3;
  localparam logic [2:0] OBC_RNG_VLP = 3'h4;
  localparam logic [2:0] OBC_RNG_EXT_XTAL = 3'h5;
  localparam logic [2:0] OBC_RNG_RSVD = 3'h6;
  localparam logic [2:0] OBC_RNG_EXT_PB4 = 3'h7;
  localparam logic [1:0] OBC_UV_OFF = 2'h3;
  localparam logic [1:0] OBC_UV_HIGH = 2'h2;
  localparam logic [1:0] OBC_UV_MED = 2'h1;
  localparam logic [1:0] OBC_UV_LOW = 2'h0;

  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam logic [12:0] OBC_BOOT_MIN_BYTES = 13'h0200;
  localparam int OBC_RSM_LONG_DELAY = 256;

  // ****************************************
  // Command and status bits
  // ****************************************
  localparam int OBC_CMD_ERASE = 0;
  localparam int OBC_ST_PROG = 0;
  localparam int OBC_ST_VALID = 1;
  localparam int OBC_ST_BUSY = 2;
  localparam int OBC_ST_REFUSED = 3;
  localparam int OBC_ST_WLOCK = 4;

  typedef enum logic [1:0] {
    OBC_LOAD = 2'b00,
    OBC_RUN = 2'b01,
    OBC_MEM_ERASE = 2'b10,
    OBC_OPT_ERASE = 2'b11
  } obc_state_t;

endpackage

// file: hw/obc_nv_byte.sv
`timescale 1ns/1ps
`default_nettype none
module obc_nv_byte #(
  parameter logic [7:0] DEFAULT_VAL = 8'hff
) (
  // Clock and power-on
  input wire logic clk,
  input wire logic store_por_n,
  // Update
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic erase,
  input wire logic [7:0] keep_mask,
  // Content
  output logic [7:0] q
);

  // ****************************************
  // Stored byte; kept bits change only at store power-on
  // ****************************************
  always_ff @(posedge clk or negedge store_por_n) begin
    if (!store_por_n) begin
      q <= DEFAULT_VAL;
    end else if (erase) begin
      q <= (q & keep_mask) | (DEFAULT_VAL & ~keep_mask);
    end else if (wr_en) begin
      q <= (q & keep_mask) | (wr_data & ~keep_mask);
    end
  end

endmodule
`default_nettype wire

// file: hw/obc_option_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module obc_option_decoder
  import obc_pkg::*;
(
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic store_por_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode and memory erase handshake
  input wire logic prog_mode,
  output logic mem_erase_req,
  input wire logic mem_erase_done,
  output logic config_valid,
  // Clock source
  output logic rc_osc_on,
  output logic [2:0] resonator_range_sel,
  output logic very_low_power_drive,
  output logic low_power_drive,
  output logic medium_power_drive,
  output logic medium_speed_drive,
  output logic high_speed_drive,
  output logic ext_clock_input,
  output logic ext_clk_from_crystal_in_pin,
  output logic ext_clk_from_port_b_bit4_pin,
  output logic range_reserved,
  output logic rsm_long_delay,
  // PLLs
  output logic pll_factor_sel,
  output logic main_pll_bypass,
  output logic fast_timer_pll_bypass,
  // Memory protection
  output logic [1:0] boot_block_size,
  output logic [12:0] boot_block_bytes,
  output logic readout_lock,
  output logic program_write_lock,
  // Supply and watchdog
  output logic [1:0] undervoltage_level_sel,
  output logic uv_detect_enable,
  output logic watchdog_type_sel,
  output logic watchdog_hw_enable,
  output logic watchdog_halt_reset
);
  import obc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  obc_state_t state_q;
  logic [7:0] store0;
  logic [7:0] store1;
  logic [7:0] act0_q;
  logic [7:0] act1_q;
  logic refused_q;
  logic refused_d;
  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic sel_opt0;
  logic sel_opt1;
  logic sel_act;
  logic sel_cmd;
  logic sel_stat;
  logic mapped;
  logic opt_sel;
  logic opt_wr_ok;
  logic erase_req;
  logic erase_ok;
  logic opt_erase;
  logic bad_wr;
  logic bad_rd;
  logic busy;
  logic [7:0] keep0;
  logic [31:0] rd_word;
  logic rc_off;
  logic [2:0] rng;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !pwrite;
  assign sel_opt0 = paddr == OBC_OFF_OPT0;
  assign sel_opt1 = paddr == OBC_OFF_OPT1;
  assign sel_act = paddr == OBC_OFF_ACTIVE;
  assign sel_cmd = paddr == OBC_OFF_CMD;
  assign sel_stat = paddr == OBC_OFF_STATUS;
  assign mapped = sel_opt0 || sel_opt1 || sel_act || sel_cmd || sel_stat;
  assign opt_sel = sel_opt0 || sel_opt1;
  assign busy = state_q != OBC_RUN;

  // Zero wait states
  assign pready = 1'b1;

  // Option bytes only move in programming mode
  assign opt_wr_ok = wr_acc && opt_sel && prog_mode && !busy;
  assign erase_req = wr_acc && sel_cmd && pwdata[OBC_CMD_ERASE];
  // Locked program memory can never be erased again
  assign erase_ok = erase_req && prog_mode && !busy && !store0[OBC_B0_WRLOCK];

  assign bad_wr = wr_acc && (!mapped || sel_act || (opt_sel && !opt_wr_ok)
                  || (erase_req && !erase_ok));
  assign bad_rd = psel && penable && !pwrite && (!mapped || (opt_sel && !prog_mode));
  assign pslverr = psel && penable && (bad_wr || bad_rd);

  // ****************************************
  // Non-volatile option store
  // ****************************************
  // Lock bit once set cannot be cleared by write or erase
  assign keep0 = {7'h00, store0[OBC_B0_WRLOCK]};
  assign opt_erase = state_q == OBC_OPT_ERASE;

  obc_nv_byte #(
    .DEFAULT_VAL(OBC_OPT0_DEFAULT)
  ) u_opt0 (
    .clk(pclk),
    .store_por_n(store_por_n),
    .wr_en(opt_wr_ok && sel_opt0),
    .wr_data(pwdata[7:0]),
    .erase(opt_erase),
    .keep_mask(keep0),
    .q(store0)
  );

  obc_nv_byte #(
    .DEFAULT_VAL(OBC_OPT1_DEFAULT)
  ) u_opt1 (
    .clk(pclk),
    .store_por_n(store_por_n),
    .wr_en(opt_wr_ok && sel_opt1),
    .wr_data(pwdata[7:0]),
    .erase(opt_erase),
    .keep_mask(8'h00),
    .q(store1)
  );

  // ****************************************
  // Load and erase sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= OBC_LOAD;
    end else begin
      unique case (state_q)
        OBC_LOAD: begin
          state_q <= OBC_RUN;
        end
        OBC_RUN: begin
          if (erase_ok) begin
            // Read-out lock forces a full memory erase first
            state_q <= store0[OBC_B0_RDLOCK] ? OBC_MEM_ERASE : OBC_OPT_ERASE;
          end
        end
        OBC_MEM_ERASE: begin
          if (mem_erase_done) begin
            state_q <= OBC_OPT_ERASE;
          end
        end
        OBC_OPT_ERASE: begin
          state_q <= OBC_RUN;
        end
      endcase
    end
  end

  assign mem_erase_req = state_q == OBC_MEM_ERASE;

  // ****************************************
  // Active settings, captured once per reset
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act0_q <= OBC_OPT0_DEFAULT;
      act1_q <= OBC_OPT1_DEFAULT;
      config_valid <= 1'b0;
    end else if (state_q == OBC_LOAD) begin
      act0_q <= store0;
      act1_q <= store1;
      config_valid <= 1'b1;
    end
  end

  // ****************************************
  // Clock source decode
  // ****************************************
  assign rc_off = act1_q[OBC_B1_RCOFF];
  assign rng = act0_q[OBC_B0_RANGE_HI:OBC_B0_RANGE_LO];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_osc_on <= 1'b0;
      resonator_range_sel <= 3'h0;
      very_low_power_drive <= 1'b0;
      low_power_drive <= 1'b0;
      medium_power_drive <= 1'b0;
      medium_speed_drive <= 1'b0;
      high_speed_drive <= 1'b0;
      ext_clock_input <= 1'b0;
      ext_clk_from_crystal_in_pin <= 1'b0;
      ext_clk_from_port_b_bit4_pin <= 1'b0;
      range_reserved <= 1'b0;
      rsm_long_delay <= 1'b0;
    end else begin
      rc_osc_on <= !rc_off;
      resonator_range_sel <= rng;
      // Drive and external clock decodes ignore the range while the RC oscillator runs
      very_low_power_drive <= rc_off && rng == OBC_RNG_VLP;
      low_power_drive <= rc_off && rng == OBC_RNG_LP;
      medium_power_drive <= rc_off && rng == OBC_RNG_MP;
      medium_speed_drive <= rc_off && rng == OBC_RNG_MS;
      high_speed_drive <= rc_off && rng == OBC_RNG_HS;
      ext_clock_input <= rc_off && (rng == OBC_RNG_EXT_XTAL || rng == OBC_RNG_EXT_PB4);
      ext_clk_from_crystal_in_pin <= rc_off && rng == OBC_RNG_EXT_XTAL;
      ext_clk_from_port_b_bit4_pin <= rc_off && rng == OBC_RNG_EXT_PB4;
      range_reserved <= rc_off && rng == OBC_RNG_RSVD;
      // Default range with RC selects the long reset delay
      rsm_long_delay <= !rc_off && rng == OBC_OPT0_DEFAULT[OBC_B0_RANGE_HI:OBC_B0_RANGE_LO];
    end
  end

  // ****************************************
  // PLL, protection, supply and watchdog
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_factor_sel <= 1'b0;
      main_pll_bypass <= 1'b0;
      fast_timer_pll_bypass <= 1'b0;
      boot_block_size <= 2'h0;
      boot_block_bytes <= 13'h0000;
      readout_lock <= 1'b0;
      program_write_lock <= 1'b0;
      undervoltage_level_sel <= 2'h0;
      uv_detect_enable <= 1'b0;
      watchdog_type_sel <= 1'b0;
      watchdog_hw_enable <= 1'b0;
      watchdog_halt_reset <= 1'b0;
    end else begin
      pll_factor_sel <= act1_q[OBC_B1_PLLFAC];
      main_pll_bypass <= act1_q[OBC_B1_PLLBYP];
      fast_timer_pll_bypass <= act1_q[OBC_B1_FTBYP];
      boot_block_size <= act0_q[OBC_B0_SIZE_HI:OBC_B0_SIZE_LO];
      boot_block_bytes <= OBC_BOOT_MIN_BYTES << act0_q[OBC_B0_SIZE_HI:OBC_B0_SIZE_LO];
      readout_lock <= act0_q[OBC_B0_RDLOCK];
      // Store bit taken too, so a fresh lock holds at once
      program_write_lock <= act0_q[OBC_B0_WRLOCK] || store0[OBC_B0_WRLOCK];
      undervoltage_level_sel <= act1_q[OBC_B1_UV_HI:OBC_B1_UV_LO];
      uv_detect_enable <= act1_q[OBC_B1_UV_HI:OBC_B1_UV_LO] != OBC_UV_OFF;
      watchdog_type_sel <= act1_q[OBC_B1_WDGSW];
      watchdog_hw_enable <= !act1_q[OBC_B1_WDGSW];
      watchdog_halt_reset <= act1_q[OBC_B1_WDGHALT];
    end
  end

  // ****************************************
  // Status flag, set beats clear
  // ****************************************
  always_comb begin
    refused_d = refused_q;
    if (wr_acc && sel_stat && pwdata[OBC_ST_REFUSED]) begin
      refused_d = 1'b0;
    end
    if (wr_acc && (opt_sel || sel_cmd) && bad_wr) begin
      refused_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= refused_d;
    end
  end

  // ****************************************
  // Read data, captured in setup phase
  // ****************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_opt0 && prog_mode) begin
      rd_word = {24'h000000, store0};
    end else if (sel_opt1 && prog_mode) begin
      rd_word = {24'h000000, store1};
    end else if (sel_act) begin
      rd_word = {16'h0000, act1_q, act0_q};
    end else if (sel_stat) begin
      rd_word[OBC_ST_PROG] = prog_mode;
      rd_word[OBC_ST_VALID] = config_valid;
      rd_word[OBC_ST_BUSY] = busy;
      rd_word[OBC_ST_REFUSED] = refused_q;
      rd_word[OBC_ST_WLOCK] = store0[OBC_B0_WRLOCK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && rd_acc) begin
      prdata <= rd_word;
    end
  end

endmodule
`default_nettype wire

// file: verif/obc_option_decoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module obc_chk
  import obc_pkg::*;
(
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode and erase
  input wire logic prog_mode,
  input wire logic mem_erase_req,
  input wire logic mem_erase_done,
  input wire logic config_valid,
  // Settings
  input wire logic rc_osc_on,
  input wire logic ext_clock_input,
  input wire logic high_speed_drive,
  input wire logic [1:0] boot_block_size,
  input wire logic [12:0] boot_block_bytes,
  input wire logic readout_lock,
  input wire logic program_write_lock,
  input wire logic [1:0] undervoltage_level_sel,
  input wire logic uv_detect_enable,
  input wire logic watchdog_type_sel,
  input wire logic watchdog_hw_enable
);
  // ****
  // Checks
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic opt_sel = paddr == OBC_OFF_OPT0 || paddr == OBC_OFF_OPT1;
  sequence acc_s;
    psel && penable;
  endsequence
  sequence erase_s;
    psel && penable && pwrite && paddr == OBC_OFF_CMD && pwdata[OBC_CMD_ERASE];
  endsequence
  ready_now_a: assert property (acc_s |-> pready) else $error("no ready");
  unmapped_err_a: assert property (acc_s ##0 paddr > OBC_OFF_STATUS |-> pslverr)
    else $error("unmapped not refused");
  prog_gate_a: assert property (acc_s ##0 (!prog_mode && opt_sel) |-> pslverr)
    else $error("option access outside prog mode");
  erase_gate_a: assert property (erase_s ##0 (!prog_mode || program_write_lock) |-> pslverr)
    else $error("erase not refused");
  erase_start_a: assert property (erase_s ##0 (readout_lock && !pslverr) |=> mem_erase_req)
    else $error("memory erase not requested");
  erase_hold_a: assert property (mem_erase_req && !mem_erase_done |=> mem_erase_req)
    else $error("memory erase dropped");
  lock_hold_a: assert property (program_write_lock |=> program_write_lock)
    else $error("write lock cleared");
  static_cfg_a: assert property (config_valid && $past(config_valid, 2) |->
    $stable(rc_osc_on) && $stable(boot_block_size) && $stable(undervoltage_level_sel))
    else $error("settings moved");
  rc_drive_a: assert property (rc_osc_on |-> !ext_clock_input && !high_speed_drive)
    else $error("range acts with rc on");
  wdg_type_a: assert property ($past(config_valid) |-> watchdog_hw_enable == !watchdog_type_sel)
    else $error("watchdog enable wrong");
  uv_enable_a: assert property ($past(config_valid) |->
    uv_detect_enable == (undervoltage_level_sel != OBC_UV_OFF)) else $error("uv enable wrong");
  boot_bytes_a: assert property ($past(config_valid) |->
    boot_block_bytes == (OBC_BOOT_MIN_BYTES << boot_block_size)) else $error("boot size wrong");
endmodule
bind obc_option_decoder obc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .prog_mode, .mem_erase_req, .mem_erase_done, .config_valid,
  .rc_osc_on, .ext_clock_input, .high_speed_drive, .boot_block_size, .boot_block_bytes,
  .readout_lock, .program_write_lock, .undervoltage_level_sel, .uv_detect_enable,
  .watchdog_type_sel, .watchdog_hw_enable);
`default_nettype wire

// file: verif/obc_prog_tool.sv
`timescale 1ns/1ps
`default_nettype none
module obc_prog_tool
  import obc_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Bus master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Mode
  output logic prog_mode
);
  // ****
  // Programming tool
  // ****
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    prog_mode = 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= (w && a == OBC_OFF_OPT0) ? (d | 32'h80) : d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken settled, just before the edge that samples it
    @(negedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(negedge pclk);
    end
    r = prdata;
    e = pslverr;
    // A missing answer shows up as an unknown error flag
    if (n == 20) begin
      e = 1'bx;
    end
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  task automatic mode(input logic m);
    @(posedge pclk);
    prog_mode <= m;
  endtask
endmodule
`default_nettype wire

// file: verif/obc_option_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module obc_option_decoder_tb_top;
  import obc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic store_por_n = 1'b0;
  logic mem_erase_done = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, prog_mode, mem_erase_req, config_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er, rc_osc_on, very_low_power_drive, low_power_drive, medium_power_drive;
  logic medium_speed_drive, high_speed_drive, ext_clock_input, ext_clk_from_crystal_in_pin;
  logic ext_clk_from_port_b_bit4_pin, range_reserved, rsm_long_delay, pll_factor_sel;
  logic main_pll_bypass, fast_timer_pll_bypass, readout_lock, program_write_lock;
  logic uv_detect_enable, watchdog_type_sel, watchdog_hw_enable, watchdog_halt_reset;
  logic [2:0] resonator_range_sel;
  logic [1:0] boot_block_size, undervoltage_level_sel;
  logic [12:0] boot_block_bytes;
  int errors = 0;
  int samples_checked = 0;
  always #25 pclk = ~pclk;
  obc_option_decoder dut (.pclk, .presetn, .store_por_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prog_mode, .mem_erase_req, .mem_erase_done,
    .config_valid, .rc_osc_on, .resonator_range_sel, .very_low_power_drive, .low_power_drive,
    .medium_power_drive, .medium_speed_drive, .high_speed_drive, .ext_clock_input,
    .ext_clk_from_crystal_in_pin, .ext_clk_from_port_b_bit4_pin, .range_reserved,
    .rsm_long_delay, .pll_factor_sel, .main_pll_bypass, .fast_timer_pll_bypass,
    .boot_block_size, .boot_block_bytes, .readout_lock, .program_write_lock,
    .undervoltage_level_sel, .uv_detect_enable, .watchdog_type_sel, .watchdog_hw_enable,
    .watchdog_halt_reset);
  obc_prog_tool tool (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prog_mode);
  // ****
  // Helpers
  // ****
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    tool.xfer(w, a, d, rd, er);
    chk(er, e, "slverr");
  endtask
  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // ****
  // Scenarios
  // ****
  task t_gate;
    tool.mode(1'b0);
    acc(1'b0, OBC_OFF_OPT0, 32'h0, 1'b1);
    acc(1'b1, OBC_OFF_OPT1, 32'h0, 1'b1);
    acc(1'b1, OBC_OFF_CMD, 32'h1, 1'b1);
    acc(1'b0, 8'h14, 32'h0, 1'b1);
    acc(1'b0, OBC_OFF_STATUS, 32'h0, 1'b0);
    chk(rd[4:0], 5'h0a, "status");
    tool.mode(1'b1);
    acc(1'b1, OBC_OFF_ACTIVE, 32'h0, 1'b1);
    $display("gate done");
  endtask
  task t_defaults;
    chk(rc_osc_on, 1'b1, "rc on");
    chk(rsm_long_delay, 1'b1, "long delay");
    chk({low_power_drive, high_speed_drive, ext_clock_input}, 3'h0, "drive idle");
    chk({resonator_range_sel, boot_block_size, readout_lock, program_write_lock}, 7'h7c, "b0");
    chk({pll_factor_sel, main_pll_bypass, fast_timer_pll_bypass, undervoltage_level_sel,
      uv_detect_enable, watchdog_type_sel, watchdog_hw_enable, watchdog_halt_reset},
      9'h1f5, "b1");
    chk(boot_block_bytes, 13'h1000, "boot bytes");
    acc(1'b0, OBC_OFF_OPT0, 32'h0, 1'b0);
    chk(rd[7:0], 8'hfc, "opt0");
    acc(1'b0, OBC_OFF_OPT1, 32'h0, 1'b0);
    chk(rd[7:0], 8'hef, "opt1");
    $display("defaults done");
  endtask
  task t_decode;
    logic [2:0] c;
    logic [8:0] tbl [8] = '{9'h080, 9'h040, 9'h020, 9'h010, 9'h100, 9'h00c, 9'h001, 9'h00a};
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      acc(1'b1, OBC_OFF_OPT0, {24'h0, 1'b1, c, c[1:0], 2'h0}, 1'b0);
      acc(1'b1, OBC_OFF_OPT1, {24'h0, c[0], c[1], c[2], 1'b1, c[1:0], c[0], c[2]}, 1'b0);
      chk(rc_osc_on, i == 0, "held");
      rst();
      chk(rc_osc_on, 1'b0, "rc off");
      chk(resonator_range_sel, c, "range");
      chk({very_low_power_drive, low_power_drive, medium_power_drive, medium_speed_drive,
        high_speed_drive}, tbl[i][8:4], "drive");
      chk({ext_clock_input, ext_clk_from_crystal_in_pin, ext_clk_from_port_b_bit4_pin,
        range_reserved}, tbl[i][3:0], "ext");
      chk(boot_block_bytes, 13'h200 << c[1:0], "boot");
      chk(readout_lock, 1'b0, "rdlock");
      chk(pll_factor_sel, c[0], "factor");
      chk(main_pll_bypass, c[1], "pll");
      chk(fast_timer_pll_bypass, c[2], "ftpll");
      chk({undervoltage_level_sel, uv_detect_enable}, {c[1:0], c[1:0] != 2'h3}, "uv");
      chk({watchdog_type_sel, watchdog_hw_enable}, {c[0], !c[0]}, "wdg");
      chk(watchdog_halt_reset, c[2], "halt");
    end
    $display("decode done");
  endtask
  task t_erase;
    acc(1'b1, OBC_OFF_OPT0, 32'hfe, 1'b0);
    rst();
    chk(readout_lock, 1'b1, "rdlock");
    acc(1'b1, OBC_OFF_CMD, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    chk(mem_erase_req, 1'b1, "erase req");
    acc(1'b0, OBC_OFF_OPT0, 32'h0, 1'b0);
    chk(rd[7:0], 8'hfe, "kept");
    mem_erase_done <= 1'b1;
    @(posedge pclk);
    mem_erase_done <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(mem_erase_req, 1'b0, "erase end");
    rst();
    t_defaults();
    $display("erase done");
  endtask
  task t_wlock;
    acc(1'b1, OBC_OFF_OPT0, 32'hfd, 1'b0);
    repeat (2) @(posedge pclk);
    chk(program_write_lock, 1'b1, "wlock");
    acc(1'b1, OBC_OFF_CMD, 32'h1, 1'b1);
    tool.xfer(1'b1, OBC_OFF_OPT0, 32'hfc, rd, er);
    acc(1'b0, OBC_OFF_OPT0, 32'h0, 1'b0);
    chk(rd[0], 1'b1, "lock bit");
    rst();
    chk(program_write_lock, 1'b1, "wlock kept");
    $display("wlock done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    store_por_n <= 1'b1;
    repeat (3) @(posedge pclk);
    t_gate();
    t_defaults();
    t_decode();
    t_erase();
    t_wlock();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
